// ===== shared/spd_defines.svh
// Constants and rule summary for the serial protect decoder
// Operation
// - Frozen guard register never changes again
// - Freeze accepted only right after guard unlock
// - Opcode 10 without guard select reads memory
// - Opcode 00 address 11xxxx enables programming
// - Opcode 01 writes word if address unprotected
// - Opcode 00 address 01xxxx fills, only when cleared
// - Opcode 00 address 00xxxx disables programming
// - Opcode 10 with guard select reads boundary
// - Guard unlock arms exactly one guard operation
// - Guard erase clears the protect register
// - Guard set stores boundary, protects that word and all above
// - Opcode 00 address 000000 with pins is freeze
// - Upper two address bits are ignored
// - Guard unlock needs programming enabled first
// - Output off during lock and unlock frames
// - Input bits sampled on serial clock rise
// - Read gives dummy zero, then continuous words
// - Chip select fall after data starts programming
// - Output shows busy low, ready high
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH
// Opcode field values
`define SPD_OP_EXT 2'h0
`define SPD_OP_WRITE 2'h1
`define SPD_OP_READ 2'h2
`define SPD_OP_ERASE 2'h3
// Sub codes in the upper address bits of the extended opcode
`define SPD_SUB_LOCK 2'h0
`define SPD_SUB_FILL 2'h1
`define SPD_SUB_UNLOCK 2'h3
`define SPD_ADDR_ONES 6'h3F
`define SPD_ADDR_ZERO 6'h00
// Bit counts of the frame
`define SPD_HDR_LAST 5'h07
`define SPD_DATA_LAST 5'h0F
`define SPD_WORD_BITS 5'h10
`define SPD_BOUND_BITS 5'h06
// Reset values of the guard register
`define SPD_BOUND_RST 6'h3F
`define SPD_CLEARED_RST 1'h1
// Self-timed programming time
`define SPD_CLK_NS 10
`define SPD_PROG_NS 10000
`define SPD_PROG_CYC ((`SPD_PROG_NS + `SPD_CLK_NS - 1) / `SPD_CLK_NS)
`endif

// ===== shared/spd_pkg.sv
// Types shared by the serial protect decoder modules
package spd_pkg;
  // Decoded instruction
  typedef enum logic [3:0] {
    I_NONE = 4'h0, I_READ = 4'h1, I_PUNLOCK = 4'h2, I_WRITE = 4'h3,
    I_FILL = 4'h4, I_LOCK = 4'h5, I_GREAD = 4'h6, I_GUNLOCK = 4'h7,
    I_GERASE = 4'h8, I_GSET = 4'h9, I_GFREEZE = 4'hA
  } spd_instr_t;
  // Frame phase
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0, PH_HDR = 3'h1, PH_DATA = 3'h2, PH_OUT = 3'h3, PH_DONE = 3'h4
  } spd_phase_t;
  // Header after the start bit
  typedef struct packed {
    logic [1:0] op;
    logic [5:0] addr;
  } spd_hdr_t;
  // Programming command queued for the array
  typedef struct packed {
    logic fill;
    logic [3:0] addr;
    logic [15:0] data;
  } spd_cmd_t;
endpackage : spd_pkg

// ===== hw/spd_buf.sv
// Two-entry command buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spd_buf #(
  parameter int W = 21
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  // All state of the buffer
  typedef struct packed {
    logic [1:0][W-1:0] slot;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } spd_buf_st_t;
  spd_buf_st_t st, next_st;
  logic push;
  logic pop;

  // ==========================================
  // Flags and next state
  assign in_ready_o = st.cnt != 2'h2;
  assign out_valid_o = st.cnt != 2'h0;
  assign out_data_o = st.slot[st.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.slot[st.wp] = in_data_i;
      next_st.wp = ~st.wp;
    end
    if (pop) begin
      next_st.rp = ~st.rp;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_buf_fills_up: assert property (push && !pop && st.cnt == 2'h1 |=> !in_ready_o && out_valid_o)
    else $error("buffer did not report full");
endmodule : spd_buf
`default_nettype wire

// ===== hw/spd_timer.sv
// Self-timed programming cycle counter
`timescale 1ns/1ps
`default_nettype none
`include "spd_defines.svh"
module spd_timer #(
  parameter int CYC = `SPD_PROG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  output logic busy_o
);
  localparam int CW = $clog2(CYC + 1);
  // All state of the timer
  typedef struct packed {
    logic busy;
    logic [CW-1:0] cnt;
  } spd_tmr_st_t;
  spd_tmr_st_t st, next_st;

  // ==========================================
  // Count down while busy
  always_comb begin
    next_st = st;
    if (st.busy) begin
      next_st.cnt = st.cnt - CW'(1);
      if (st.cnt == CW'(1)) begin
        next_st.busy = 1'b0;
      end
    end else if (start_i) begin
      next_st.busy = 1'b1;
      next_st.cnt = CW'(CYC);
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign busy_o = st.busy;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_timer_start_load: assert property (start_i && !busy_o |=> busy_o && st.cnt == CW'(CYC))
    else $error("timer did not load full count");
  chk_timer_end_done: assert property (busy_o && st.cnt == CW'(1) |=> !busy_o)
    else $error("timer did not stop at end");
endmodule : spd_timer
`default_nettype wire

// ===== hw/spd_decoder.sv
// Serial command decoder, guard register and word array
`timescale 1ns/1ps
`default_nettype none
`include "spd_defines.svh"
module spd_decoder #(
  parameter int PROG_CYC = `SPD_PROG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic chip_select_i,
  input wire logic serial_clock_i,
  input wire logic serial_input_i,
  input wire logic guard_register_select_i,
  input wire logic program_allow_pin_i,
  output logic serial_output_o,
  output logic serial_output_en_o,
  output logic program_enabled_o,
  output logic guard_frozen_o,
  output logic guard_cleared_o,
  output logic [5:0] guard_boundary_o,
  output logic busy_o
);
  import spd_pkg::*;

  // ==========================================
  // State
  typedef struct packed {
    spd_phase_t phase;       // Frame phase
    logic sclk_q;            // Serial clock last cycle
    logic cs_q;              // Chip select last cycle
    logic [4:0] cnt;         // Bit counter in frame
    spd_hdr_t hdr;           // Opcode and address
    spd_instr_t instr;       // Instruction of this frame
    logic [15:0] data;       // Incoming data word
    logic loaded;            // Accepted word ready to program
    logic pend;              // Command waiting for buffer
    spd_cmd_t pcmd;          // That command
    logic status;            // Show ready or busy
    logic prog_en;           // Programming allowed
    logic armed;             // Guard unlock just before
    logic frozen;            // Guard register locked for good
    logic cleared;           // Guard register cleared
    logic [5:0] bound;       // First protected address
    logic [15:0] shreg;      // Output shifter
    logic [4:0] out_cnt;     // Bits left in shifter
    logic rd_mem;            // Output stream from array
    logic [3:0] rd_addr;     // Word now being read
    logic dout;              // Output pin level
    logic doe;               // Output pin enable
    logic [15:0][15:0] mem;  // Word array
  } spd_dec_st_t;
  spd_dec_st_t st, next_st;

  logic rise;          // Serial clock rising in frame
  logic cs_fall;       // Chip select falling
  logic hdr_end;       // Last header bit sampled now
  spd_hdr_t nh;        // Header including this bit
  spd_instr_t dec;     // Decoded instruction
  logic busy_any;      // Programming in flight
  logic push;          // Command enters buffer
  logic in_ready;      // Buffer has room
  logic out_valid;     // Buffer holds a command
  logic pop;           // Command starts programming
  logic t_busy;        // Self-timed cycle running
  spd_cmd_t bcmd;      // Command at buffer head

  // ==========================================
  // Helpers
  // Word protected by current boundary
  function automatic logic spd_prot(input logic [3:0] a, input logic [5:0] b, input logic clr);
    spd_prot = !clr && (a >= b[3:0]);
  endfunction : spd_prot

  // Header decode; guard select picks the guard register
  function automatic spd_instr_t spd_decode(input spd_hdr_t h, input logic pre);
    spd_instr_t r;
    r = I_NONE;
    unique case (h.op)
      `SPD_OP_READ: r = pre ? I_GREAD : I_READ;
      `SPD_OP_WRITE: r = pre ? I_GSET : I_WRITE;
      `SPD_OP_ERASE: r = (pre && h.addr == `SPD_ADDR_ONES) ? I_GERASE : I_NONE;
      `SPD_OP_EXT: begin
        if (pre && h.addr == `SPD_ADDR_ZERO) begin
          r = I_GFREEZE;
        end else if (h.addr[5:4] == `SPD_SUB_UNLOCK) begin
          r = pre ? I_GUNLOCK : I_PUNLOCK;
        end else if (!pre && h.addr[5:4] == `SPD_SUB_FILL) begin
          r = I_FILL;
        end else if (!pre && h.addr[5:4] == `SPD_SUB_LOCK) begin
          r = I_LOCK;
        end
      end
    endcase
    return r;
  endfunction : spd_decode

  // ==========================================
  // Edge detect and decode
  // sample on rise
  assign rise = chip_select_i && serial_clock_i && !st.sclk_q;
  assign cs_fall = st.cs_q && !chip_select_i;
  assign hdr_end = rise && st.phase == PH_HDR && st.cnt == `SPD_HDR_LAST;
  assign nh = {st.hdr[6:0], serial_input_i};
  assign dec = spd_decode(nh, guard_register_select_i);
  assign busy_any = st.pend || out_valid || t_busy;
  assign push = st.pend && in_ready;
  // Only one word programs at a time
  assign pop = out_valid && !t_busy;

  // ==========================================
  // Programming path
  spd_buf #(
    .W($bits(spd_cmd_t))
  ) u_buf (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(st.pend),
    .in_ready_o(in_ready),
    .in_data_i(st.pcmd),
    .out_valid_o(out_valid),
    .out_ready_i(!t_busy),
    .out_data_o(bcmd)
  );

  spd_timer #(
    .CYC(PROG_CYC)
  ) u_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(pop),
    .busy_o(t_busy)
  );

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.sclk_q = serial_clock_i;
    next_st.cs_q = chip_select_i;
    // Array update when a cycle starts
    if (pop) begin
      if (bcmd.fill) begin
        for (int i = 0; i < 16; i++) begin
          next_st.mem[i] = bcmd.data;
        end
      end else begin
        next_st.mem[bcmd.addr] = bcmd.data;
      end
    end
    if (push) begin
      next_st.pend = 1'b0;
    end
    if (!chip_select_i) begin
      // Chip select low resets the frame
      next_st.phase = PH_IDLE;
      next_st.doe = 1'b0;
      next_st.dout = 1'b0;
      next_st.loaded = 1'b0;
      if (cs_fall && st.loaded) begin
        next_st.pend = 1'b1;
        next_st.pcmd = '{fill: st.instr == I_FILL, addr: st.hdr.addr[3:0], data: st.data};
        next_st.status = 1'b1;
      end
    end else begin
      if (st.phase == PH_IDLE) begin
        next_st.doe = st.status;
        next_st.dout = !busy_any;
      end
      if (rise) begin
        unique case (st.phase)
          PH_IDLE: begin
            // Leading zeros are skipped until the start bit
            if (serial_input_i) begin
              next_st.phase = PH_HDR;
              next_st.cnt = 5'h00;
              next_st.status = 1'b0;
              next_st.doe = 1'b0;
            end
          end
          PH_HDR: begin
            next_st.hdr = nh;
            next_st.cnt = st.cnt + 5'h01;
            if (st.cnt == `SPD_HDR_LAST) begin
              next_st.instr = dec;
              next_st.phase = PH_DONE;
              next_st.cnt = 5'h00;
              // Any finished header uses up the arm
              next_st.armed = 1'b0;
              unique case (dec)
                I_READ: begin
                  next_st.rd_addr = nh.addr[3:0];
                  next_st.shreg = st.mem[nh.addr[3:0]];
                  next_st.out_cnt = `SPD_WORD_BITS;
                  next_st.rd_mem = 1'b1;
                  next_st.doe = 1'b1;
                  next_st.dout = 1'b0;
                  next_st.phase = PH_OUT;
                end
                I_GREAD: begin
                  next_st.shreg = {st.bound, 10'h000};
                  next_st.out_cnt = `SPD_BOUND_BITS;
                  next_st.rd_mem = 1'b0;
                  next_st.doe = 1'b1;
                  next_st.dout = 1'b0;
                  next_st.phase = PH_OUT;
                end
                I_PUNLOCK: begin
                  if (program_allow_pin_i) begin
                    next_st.prog_en = 1'b1;
                  end
                end
                I_LOCK: begin
                  next_st.prog_en = 1'b0;
                end
                I_WRITE, I_FILL: begin
                  // fill only when cleared
                  // A second word while one still waits for the buffer is dropped
                  if (!(program_allow_pin_i && st.prog_en && !st.pend &&
                        (dec == I_FILL ? st.cleared : !spd_prot(nh.addr[3:0], st.bound, st.cleared)))) begin
                    next_st.instr = I_NONE;
                  end
                  next_st.phase = PH_DATA;
                end
                I_GUNLOCK: begin
                  next_st.armed = program_allow_pin_i && st.prog_en;
                end
                I_GERASE: begin
                  if (st.armed && program_allow_pin_i && !st.frozen) begin
                    next_st.cleared = 1'b1;
                    next_st.bound = `SPD_ADDR_ONES;
                  end
                end
                I_GSET: begin
                  if (st.armed && program_allow_pin_i && !st.frozen && st.cleared) begin
                    next_st.cleared = 1'b0;
                    next_st.bound = nh.addr;
                  end
                end
                I_GFREEZE: begin
                  if (st.armed && program_allow_pin_i) begin
                    next_st.frozen = 1'b1;
                  end
                end
                I_NONE: begin
                  next_st.doe = 1'b0;
                end
                default: begin
                  next_st.instr = I_NONE;
                end
              endcase
            end
          end
          PH_DATA: begin
            next_st.data = {st.data[14:0], serial_input_i};
            next_st.cnt = st.cnt + 5'h01;
            if (st.cnt == `SPD_DATA_LAST) begin
              next_st.phase = PH_DONE;
              next_st.loaded = st.instr != I_NONE;
            end
          end
          PH_OUT: begin
            if (st.out_cnt != 5'h00) begin
              next_st.dout = st.shreg[15];
              next_st.shreg = {st.shreg[14:0], 1'b0};
              next_st.out_cnt = st.out_cnt - 5'h01;
            end else if (st.rd_mem) begin
              next_st.rd_addr = st.rd_addr + 4'h1;
              next_st.dout = st.mem[st.rd_addr + 4'h1][15];
              next_st.shreg = {st.mem[st.rd_addr + 4'h1][14:0], 1'b0};
              next_st.out_cnt = `SPD_DATA_LAST;
            end else begin
              next_st.dout = 1'b0;
            end
          end
          PH_DONE: begin
            // Late clock edge after data cancels the write
            next_st.loaded = 1'b0;
            next_st.doe = 1'b0;
          end
          default: begin
            next_st.phase = PH_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.bound <= `SPD_BOUND_RST;
      st.cleared <= `SPD_CLEARED_RST;
    end else begin
      st <= next_st;
    end
  end

  assign serial_output_o = st.dout;
  assign serial_output_en_o = st.doe;
  assign program_enabled_o = st.prog_en;
  assign guard_frozen_o = st.frozen;
  assign guard_cleared_o = st.cleared;
  assign guard_boundary_o = st.bound;
  assign busy_o = busy_any;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_frame_end;
    cs_fall && st.loaded;
  endsequence
  sequence s_read_hdr;
    hdr_end && dec == I_READ;
  endsequence
  chk_freeze_holds_bound: assert property (st.frozen |=> $stable(st.bound) && $stable(st.cleared))
    else $error("guard register changed after freeze");
  chk_freeze_after_arm: assert property ($rose(st.frozen) |-> $past(st.armed))
    else $error("freeze taken without unlock before");
  chk_guard_needs_arm: assert property ($changed(st.bound) |-> $past(st.armed))
    else $error("boundary changed without unlock before");
  chk_unlock_needs_prog: assert property ($rose(st.armed) |-> $past(st.prog_en))
    else $error("guard unlock armed while programming off");
  chk_read_dummy_bit: assert property (s_read_hdr |=> serial_output_en_o && !serial_output_o)
    else $error("read did not start with dummy zero");
  chk_lock_clears_en: assert property (hdr_end && dec == I_LOCK |=> !program_enabled_o)
    else $error("program lock left programming on");
  chk_quiet_frames: assert property (st.phase == PH_DONE && (st.instr == I_LOCK || st.instr == I_PUNLOCK ||
    st.instr == I_GUNLOCK) |-> !serial_output_en_o)
    else $error("output driven in lock or unlock frame");
  chk_prog_start: assert property (s_frame_end |=> st.pend ##1 busy_o)
    else $error("programming not started by chip select fall");
  chk_status_level: assert property (chip_select_i && st.status && st.phase == PH_IDLE ##1 st.phase == PH_IDLE
    |-> serial_output_en_o && serial_output_o == !$past(busy_any))
    else $error("status level wrong");
  chk_write_unprot: assert property (push && !st.pcmd.fill |-> !spd_prot(st.pcmd.addr, st.bound, st.cleared))
    else $error("protected word queued");
endmodule : spd_decoder
`default_nettype wire

// ===== dv/spd_host.sv
// Host model driving the serial link of the decoder
`timescale 1ns/1ps
`default_nettype none
module spd_host (
  input wire logic clk_i,
  output logic cs_o,
  output logic sclk_o,
  output logic sdi_o,
  output logic grs_o,
  output logic pa_o,
  input wire logic sdo_i,
  input wire logic sdo_en_i
);
  // ========================================
  // Line state
  // Wire level; floats while undriven
  wire logic line = sdo_en_i ? sdo_i : 1'bz;
  logic en_seen;  // Drive seen in this frame
  logic [63:0] q;  // One bit per rise, newest low
  // Quiet link from time zero
  initial begin
    {cs_o, sclk_o, sdi_o, grs_o, pa_o, en_seen} = 6'h00;
    q = 64'h0;
  end
  // Sticky record of output drive
  always @(posedge clk_i) begin
    if (cs_o && sdo_en_i) en_seen <= 1'h1;
  end
  // ========================================
  // Bit and frame tasks
  // data moves while clock is low
  task automatic sbit(input logic b);
    @(posedge clk_i) begin
      sclk_o <= 1'h0;
      sdi_o <= b;
    end
    @(posedge clk_i) sclk_o <= 1'h1;
    repeat (2) @(posedge clk_i);
    #1 q = {q[62:0], line};
  endtask : sbit
  // Start bit, header, data, extra rises
  task automatic xfer(input logic [7:0] hd, input logic g, input logic p,
                      input logic [15:0] d, input int nd, input int nr);
    @(posedge clk_i) begin
      cs_o <= 1'h1;
      grs_o <= g;
      pa_o <= p;
    end
    en_seen = 1'h0;
    sbit(1'h1);
    for (int i = 7; i >= 0; i--) sbit(hd[i]);
    for (int i = 15; i > 15 - nd; i--) sbit(d[i]);
    repeat (nr) sbit(1'h0);
    @(posedge clk_i) begin
      cs_o <= 1'h0;
      sclk_o <= 1'h0;
    end
    repeat (2) @(posedge clk_i);
  endtask : xfer
  // Select high with no start bit
  task automatic stat(output logic s);
    @(posedge clk_i) cs_o <= 1'h1;
    repeat (3) @(posedge clk_i);
    #1 s = line;
  endtask : stat
  // End a status look
  task automatic idle();
    @(posedge clk_i) cs_o <= 1'h0;
    repeat (2) @(posedge clk_i);
  endtask : idle
endmodule : spd_host
`default_nettype wire

// ===== dv/spd_decoder_tb.sv
// Self-checking bench for the serial protect decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module spd_decoder_tb;
  import spd_pkg::*;
  localparam int PCYC = 40;  // Short program time keeps runs brief
  logic clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic cs, sclk, sdi, grs, pa, sdo, sdo_en;  // Link
  logic pen, frz, clr, busy;  // Flags
  logic [5:0] bnd;  // Boundary
  int failures = 0;
  int n_compared = 0;
  // ========================================
  // Clock and instances
  always #5 clk_i = ~clk_i;
  spd_host h (.clk_i(clk_i), .cs_o(cs), .sclk_o(sclk), .sdi_o(sdi), .grs_o(grs), .pa_o(pa),
    .sdo_i(sdo), .sdo_en_i(sdo_en));
  spd_decoder #(.PROG_CYC(PCYC)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .chip_select_i(cs),
    .serial_clock_i(sclk), .serial_input_i(sdi), .guard_register_select_i(grs),
    .program_allow_pin_i(pa), .serial_output_o(sdo), .serial_output_en_o(sdo_en),
    .program_enabled_o(pen), .guard_frozen_o(frz), .guard_cleared_o(clr),
    .guard_boundary_o(bnd), .busy_o(busy));
  // ========================================
  // Helpers
  // Guard frame, both pins high
  task automatic gx(input logic [7:0] hd);
    h.xfer(hd, 1'h1, 1'h1, 16'h0000, 0, 0);
  endtask : gx
  // Read n bits past the dummy
  task automatic rd(input logic [7:0] hd, input logic g, input int n);
    h.xfer(hd, g, 1'h0, 16'h0000, 0, n);
  endtask : rd
  // Accepted program frame, busy then ready
  task automatic wr_ok(input logic [7:0] hd, input logic [15:0] d);
    logic s;
    int n;
    h.xfer(hd, 1'h0, 1'h1, d, 16, 0);
    h.stat(s);
    `CHK(busy, 1'h1)
    `CHK(s, 1'h0)
    n = 0;
    while (busy !== 1'h0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n < 200, 1'h1)
    h.stat(s);
    `CHK(s, 1'h1)
    h.idle();
  endtask : wr_ok
  // Refused program frame, no busy follows
  task automatic wr_no(input logic [7:0] hd, input logic [15:0] d);
    h.xfer(hd, 1'h0, 1'h1, d, 16, 0);
    repeat (2) @(posedge clk_i);
    #1 `CHK(busy, 1'h0)
  endtask : wr_no
  // ========================================
  // Scenarios
  // Reset state, then guard unlock with programming off
  task automatic t_early();
    `CHK({pen, frz, clr, bnd, busy, sdo_en}, {1'h0, 1'h0, 1'h1, 6'h3F, 1'h0, 1'h0})
    gx(8'h30);
    gx(8'h42);
    `CHK(bnd, 6'h3F)
  endtask : t_early
  // Programming on and off; pin gating; line quiet
  task automatic t_prog();
    h.xfer(8'h3A, 1'h0, 1'h0, 16'h0000, 0, 0);
    `CHK(pen, 1'h0)
    h.xfer(8'h3A, 1'h0, 1'h1, 16'h0000, 0, 0);
    `CHK({pen, h.en_seen}, 2'h2)
    h.xfer(8'h0C, 1'h0, 1'h0, 16'h0000, 0, 0);
    `CHK({pen, h.en_seen}, 2'h0)
    h.xfer(8'h30, 1'h0, 1'h1, 16'h0000, 0, 0);
  endtask : t_prog
  // Fill, aliased write, sequential read
  task automatic t_rw();
    wr_ok(8'h15, 16'h1234);
    wr_ok(8'h75, 16'hA5C3);
    rd(8'hA5, 1'h0, 32);
    `CHK(h.q[32:0], {1'h0, 16'hA5C3, 16'h1234})
  endtask : t_rw
  // Boundary set, arming, protection at the edge
  task automatic t_guard();
    rd(8'h9B, 1'h1, 6);
    `CHK(h.q[6:0], {1'h0, 6'h3F})
    gx(8'h48);
    `CHK(bnd, 6'h3F)
    gx(8'h30);
    `CHK(h.en_seen, 1'h0)
    gx(8'h48);
    `CHK(bnd, 6'h08)
    gx(8'h44);
    `CHK(bnd, 6'h08)
    rd(8'h9B, 1'h1, 6);
    `CHK(h.q[6:0], {1'h0, 6'h08})
    wr_no(8'h48, 16'hBEEF);
    wr_no(8'h15, 16'hFFFF);
    wr_ok(8'h63, 16'h5A5A);
    // A rise after the last data bit cancels the write
    h.xfer(8'h63, 1'h0, 1'h1, 16'hFFFF, 16, 1);
    `CHK(busy, 1'h0)
    rd(8'h83, 1'h0, 16);
    `CHK(h.q[16:0], {1'h0, 16'h5A5A})
    rd(8'h88, 1'h0, 16);
    `CHK(h.q[16:0], {1'h0, 16'h1234})
  endtask : t_guard
  // Erase, stale arm, freeze, then no change
  task automatic t_freeze();
    gx(8'h30);
    gx(8'hFF);
    `CHK({clr, bnd}, 7'h7F)
    gx(8'h30);
    gx(8'h4A);
    gx(8'h30);
    rd(8'h9B, 1'h1, 6);
    gx(8'h00);
    `CHK(frz, 1'h0)
    gx(8'h30);
    gx(8'h00);
    `CHK(frz, 1'h1)
    gx(8'h30);
    gx(8'hFF);
    `CHK({frz, clr, bnd}, {1'h1, 1'h0, 6'h0A})
  endtask : t_freeze
  // Verdict and end of run
  task automatic complete_run();
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // Reset, then scenarios in order
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    #1 t_early();
    t_prog();
    t_rw();
    t_guard();
    t_freeze();
    complete_run();
  end
  // Watchdog well past the expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    complete_run();
  end
endmodule : spd_decoder_tb
`default_nettype wire
